// >>> design/fwp_word_program.sv
// Purpose: single-word self-programming controller for on-chip program flash
// Assumes: core reaches the registers over classic Wishbone, 8-bit data in low lane
// Notes:   the core is held by core_stall_o for the whole program cycle
//
// What this block does
// - one program cycle writes exactly one word
// - start after correct unlock begins cycle
// - core stalled for whole program cycle
// - reset-aborted cycle sets program abort flag
// - unlock key register has no storage
// - control register bit layout, unused bits zero
// - pointer in three bytes, separate data latch
// - holding registers persist after program cycle
// - internal timer ends the cycle itself
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/100ps
module fwp_word_program #(
    parameter int PROG_TIME_NS = 1000,
    parameter int TIMER_W      = 16
) (
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // wishbone slave
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [7:0]                 wb_adr_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic      [31:0]                wb_dat_o,
    output logic                            wb_ack_o,
    // reset sources that may cut a cycle short, asynchronous pins
    input  wire logic                       external_master_reset_i,
    input  wire logic                       watchdog_reset_i,
    // core and flash array
    output logic                            core_stall_o,
    output fwp_pkg::fwp_flash_cmd_type      flash_cmd_o
);

    // program time in cycles, rounded up, at least one
    localparam int PROG_CYCLES_RAW =
        (PROG_TIME_NS + fwp_pkg::CLK_PERIOD_NS - 1) / fwp_pkg::CLK_PERIOD_NS;
    localparam int PROG_CYCLES = (PROG_CYCLES_RAW < 1) ? 1 : PROG_CYCLES_RAW;

    // pointer step of one byte, built at full pointer width
    localparam logic [fwp_pkg::PTR_W-1:0] PTR_ONE = {{(fwp_pkg::PTR_W-1){1'b0}}, 1'b1};

    typedef struct packed {
        logic                         ack;
        logic [31:0]                  rdat;
        logic [fwp_pkg::UPPER_W-1:0]  ptr_u;
        logic [7:0]                   ptr_h;
        logic [7:0]                   ptr_l;
        logic [7:0]                   latch;
        logic [7:0]                   intctl;
        logic                         word_program_select;
        logic                         erase_select;
        logic                         program_abort_flag;
        logic                         flash_write_permit;
        logic                         start;
        fwp_pkg::fwp_key_type         key;
        logic [7:0]                   hold_lo;
        logic [7:0]                   hold_hi;
        logic                         busy;
        logic                         launch;
        logic                         abort;
        logic [1:0]                   mr_sync;
        logic [1:0]                   wd_sync;
        fwp_pkg::fwp_flash_cmd_type   cmd;
    } fwp_state_type;

    fwp_state_type st_reg;
    fwp_state_type st_next;
    logic          timer_done;

    // true when the pending request addresses the given register
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction : hit

    // control register image as seen by a read
    function automatic logic [7:0] ctl_image(input fwp_state_type s);
        logic [7:0] v;
        v                         = fwp_pkg::BYTE_RESET;
        v[fwp_pkg::CTL_WORD_PROGRAM_SELECT_BIT] = s.word_program_select;
        v[fwp_pkg::CTL_ERASE_BIT] = s.erase_select;
        v[fwp_pkg::CTL_ERR_BIT]   = s.program_abort_flag;
        v[fwp_pkg::CTL_FLASH_WRITE_PERMIT_BIT]  = s.flash_write_permit;
        v[fwp_pkg::CTL_START_BIT] = s.start;
        ctl_image                 = v;
    endfunction : ctl_image

    // internal programming timer, runs from the launch pulse
    fwp_prog_timer #(
        .CNT_W  (TIMER_W),
        .CYCLES (PROG_CYCLES)
    ) u_timer (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (st_reg.launch),
        .abort_i (st_reg.abort),
        .done_o  (timer_done)
    );

    // next-state logic: bus slave, unlock sequencer, program cycle
    always_comb begin
        logic                        req;
        logic                        wr;
        logic [7:0]                  wbyte;
        logic [fwp_pkg::PTR_W-1:0]   ptr;
        logic [fwp_pkg::PTR_W-1:0]   ptr_inc;
        logic                        abort_evt;
        logic                        err_clear;

        req       = 1'b0;
        wr        = 1'b0;
        wbyte     = fwp_pkg::BYTE_RESET;
        ptr       = '0;
        ptr_inc   = '0;
        abort_evt = 1'b0;
        err_clear = 1'b0;
        st_next   = st_reg;

        st_next.launch = 1'b0;
        st_next.abort  = 1'b0;

        // two-stage synchronisers for the reset sources
        st_next.mr_sync = {st_reg.mr_sync[0], external_master_reset_i};
        st_next.wd_sync = {st_reg.wd_sync[0], watchdog_reset_i};

        // one access per request; ack drops the cycle after it rose
        req        = wb_cyc_i && wb_stb_i && !st_reg.ack;
        wr         = req && wb_we_i && wb_sel_i[0];
        wbyte      = wb_dat_i[7:0];
        st_next.ack = req;

        ptr     = {st_reg.ptr_u, st_reg.ptr_h, st_reg.ptr_l};
        ptr_inc = ptr + PTR_ONE;

        // read data, registered with ack; unmapped reads give zero
        if (req) begin
            st_next.rdat = fwp_pkg::WORD_ZERO;
            if (hit(wb_adr_i, fwp_pkg::OFF_PTR_UPPER)) begin
                st_next.rdat[fwp_pkg::UPPER_W-1:0] = st_reg.ptr_u;
            end else if (hit(wb_adr_i, fwp_pkg::OFF_PTR_HIGH)) begin
                st_next.rdat[7:0] = st_reg.ptr_h;
            end else if (hit(wb_adr_i, fwp_pkg::OFF_PTR_LOW)) begin
                st_next.rdat[7:0] = st_reg.ptr_l;
            end else if (hit(wb_adr_i, fwp_pkg::OFF_LATCH)) begin
                st_next.rdat[7:0] = st_reg.latch;
            end else if (hit(wb_adr_i, fwp_pkg::OFF_INTCTL)) begin
                st_next.rdat[7:0] = st_reg.intctl;
            end else if (hit(wb_adr_i, fwp_pkg::OFF_CTL)) begin
                st_next.rdat[7:0] = ctl_image(st_reg);
            end else if (hit(wb_adr_i, fwp_pkg::OFF_HOLD)) begin
                st_next.rdat[15:0] = {st_reg.hold_hi, st_reg.hold_lo};
            end else begin
                st_next.rdat = fwp_pkg::WORD_ZERO;                     // key reads zero
            end
        end

        // register writes; pointer and holding data frozen while busy
        if (wr && !st_reg.busy) begin
            if (hit(wb_adr_i, fwp_pkg::OFF_PTR_UPPER)) begin
                st_next.ptr_u = wbyte[fwp_pkg::UPPER_W-1:0];
            end
            if (hit(wb_adr_i, fwp_pkg::OFF_PTR_HIGH)) begin
                st_next.ptr_h = wbyte;
            end
            if (hit(wb_adr_i, fwp_pkg::OFF_PTR_LOW)) begin
                st_next.ptr_l = wbyte;
            end
            if (hit(wb_adr_i, fwp_pkg::OFF_LATCH)) begin
                st_next.latch = wbyte;
            end
            if (hit(wb_adr_i, fwp_pkg::OFF_INTCTL)) begin
                st_next.intctl = wbyte;
            end
            // table write op: latch byte into the holding byte picked by bit 0
            if (hit(wb_adr_i, fwp_pkg::OFF_TBL_WRITE)) begin
                if (ptr[0]) begin
                    st_next.hold_hi = st_reg.latch;
                end else begin
                    st_next.hold_lo = st_reg.latch;
                end
                if (wbyte[fwp_pkg::TABLE_WRITE_OP_POSTINC_BIT]) begin
                    st_next.ptr_u = ptr_inc[fwp_pkg::PTR_W-1:16];
                    st_next.ptr_h = ptr_inc[15:8];
                    st_next.ptr_l = ptr_inc[7:0];
                end
            end
        end

        // unlock key: nothing stored, only the sequence advances
        if (wr && hit(wb_adr_i, fwp_pkg::OFF_KEY)) begin
            if (wbyte == fwp_pkg::KEY_FIRST) begin
                st_next.key = fwp_pkg::KEY_GOT_FIRST;
            end else if (wbyte == fwp_pkg::KEY_SECOND &&
                         st_reg.key == fwp_pkg::KEY_GOT_FIRST) begin
                st_next.key = fwp_pkg::KEY_ARMED;
            end else begin
                st_next.key = fwp_pkg::KEY_IDLE;
            end
        end else if (wr) begin
            // any other register write breaks the sequence
            st_next.key = fwp_pkg::KEY_IDLE;
        end

        // control register write
        if (wr && hit(wb_adr_i, fwp_pkg::OFF_CTL)) begin
            st_next.word_program_select = wbyte[fwp_pkg::CTL_WORD_PROGRAM_SELECT_BIT];
            st_next.erase_select        = wbyte[fwp_pkg::CTL_ERASE_BIT];
            st_next.flash_write_permit  = wbyte[fwp_pkg::CTL_FLASH_WRITE_PERMIT_BIT];
            err_clear = !wbyte[fwp_pkg::CTL_ERR_BIT];
            // start only from an armed key, with permit and word mode already set
            if (wbyte[fwp_pkg::CTL_START_BIT] && !st_reg.busy &&
                st_reg.key == fwp_pkg::KEY_ARMED &&
                st_reg.flash_write_permit &&
                st_reg.word_program_select) begin
                st_next.start    = 1'b1;
                st_next.busy     = 1'b1;
                st_next.launch   = 1'b1;
                st_next.cmd.prog = 1'b1;
                st_next.cmd.addr = {ptr[fwp_pkg::PTR_W-1:1], 1'b0};
                st_next.cmd.data = {st_reg.hold_hi, st_reg.hold_lo};
            end
        end

        // abort by external master reset or watchdog during a cycle
        abort_evt = st_reg.busy && (st_reg.mr_sync[1] || st_reg.wd_sync[1]);

        // timer expiry or abort ends the cycle; holding bytes kept
        if (abort_evt) begin
            st_next.abort    = 1'b1;
            st_next.busy     = 1'b0;
            st_next.start    = 1'b0;
            st_next.cmd.prog = 1'b0;
        end else if (timer_done && st_reg.busy) begin
            st_next.busy     = 1'b0;
            st_next.start    = 1'b0;
            st_next.cmd.prog = 1'b0;
        end

        // abort flag: a set in the same cycle beats a software clear
        if (abort_evt) begin
            st_next.program_abort_flag = 1'b1;
        end else if (err_clear) begin
            st_next.program_abort_flag = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign wb_ack_o     = st_reg.ack;
    assign wb_dat_o     = st_reg.rdat;
    assign core_stall_o = st_reg.busy;
    assign flash_cmd_o  = st_reg.cmd;

endmodule : fwp_word_program

// >>> design/fwp_pkg.sv
// Purpose: shared constants and types of the flash word program controller
// Assumes: 8-bit registers, one per aligned 32-bit Wishbone word
// Notes:   byte offsets below are decoded on wb_adr_i[7:2]
package fwp_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] OFF_PTR_UPPER = 8'h00;
    localparam logic [7:0] OFF_PTR_HIGH  = 8'h04;
    localparam logic [7:0] OFF_PTR_LOW   = 8'h08;
    localparam logic [7:0] OFF_LATCH     = 8'h0C;
    localparam logic [7:0] OFF_INTCTL    = 8'h10;
    localparam logic [7:0] OFF_KEY       = 8'h14;
    localparam logic [7:0] OFF_CTL       = 8'h18;
    localparam logic [7:0] OFF_TBL_WRITE = 8'h1C;
    localparam logic [7:0] OFF_HOLD      = 8'h20;

    // flash_program_control field positions
    localparam int CTL_WORD_PROGRAM_SELECT_BIT = 5;
    localparam int CTL_ERASE_BIT = 4;
    localparam int CTL_ERR_BIT   = 3;
    localparam int CTL_FLASH_WRITE_PERMIT_BIT  = 2;
    localparam int CTL_START_BIT = 1;

    // table write op field: request post-increment of the pointer
    localparam int TABLE_WRITE_OP_POSTINC_BIT = 0;

    // unlock key values, in the order they must arrive
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // pointer geometry
    localparam int PTR_W   = 22;
    localparam int UPPER_W = 6;

    // reset values
    localparam logic [7:0]  BYTE_RESET = 8'h00;
    localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

    // clock period, used to turn times into cycle counts
    localparam int CLK_PERIOD_NS = 10;

    // progress through the two-value unlock sequence
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_GOT_FIRST,
        KEY_ARMED
    } fwp_key_type;

    // command to the flash array
    typedef struct packed {
        logic               prog;
        logic [PTR_W-1:0]   addr;
        logic [15:0]        data;
    } fwp_flash_cmd_type;

endpackage : fwp_pkg

// >>> design/fwp_prog_timer.sv
// Purpose: internal programming timer that times one program cycle
// Assumes: start_i and abort_i are one-cycle pulses on clk_i
// Notes:   done_o pulses once when the count expires, never after an abort
`timescale 1ns/100ps
module fwp_prog_timer #(
    parameter int CNT_W  = 16,
    parameter int CYCLES = 100
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // control
    input  wire logic start_i,
    input  wire logic abort_i,
    // status
    output logic      done_o
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             done;
    } fwp_timer_state_type;

    localparam logic [CNT_W-1:0] LOAD_VAL = CNT_W'(CYCLES);
    localparam logic [CNT_W-1:0] ONE      = CNT_W'(1);

    fwp_timer_state_type st_reg;
    fwp_timer_state_type st_next;

    // count down from the load value; abort wins over everything
    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (abort_i) begin
            st_next.cnt = '0;
        end else if (start_i) begin
            st_next.cnt = LOAD_VAL;
        end else if (st_reg.cnt != '0) begin
            st_next.cnt  = st_reg.cnt - ONE;
            st_next.done = (st_reg.cnt == ONE);
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign done_o = st_reg.done;

endmodule : fwp_prog_timer

// >>> verif/fwp_wp_assertions.sv
// Purpose: port-level checks of the word program controller
// Assumes: one clock, synchronous active-high reset
// Notes:   bound into every fwp_word_program instance
`timescale 1ns/100ps
module fwp_wp_assertions #(
    parameter int PROG_TIME_NS = 1000
) (
    // clock, reset and bus
    input wire logic                       clk_i,
    input wire logic                       rst_i,
    input wire logic                       wb_cyc_i,
    input wire logic                       wb_stb_i,
    input wire logic                       wb_we_i,
    input wire logic [7:0]                 wb_adr_i,
    input wire logic [3:0]                 wb_sel_i,
    input wire logic [31:0]                wb_dat_i,
    input wire logic                       wb_ack_o,
    // core and flash side
    input wire logic                       core_stall_o,
    input wire fwp_pkg::fwp_flash_cmd_type flash_cmd_o
);
    // longest legal stall: timer count plus launch and finish edges
    localparam int STALL_MAX = PROG_TIME_NS / fwp_pkg::CLK_PERIOD_NS + 6;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a request not yet answered
    sequence s_request;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // the acked control write that carries the start bit
    sequence s_start_write;
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == fwp_pkg::OFF_CTL[7:2]
            && wb_dat_i[fwp_pkg::CTL_START_BIT];
    endsequence
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_after_req: assert property (s_request |=> wb_ack_o)
        else $error("request not acked in the next cycle");
    a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_prog_is_stall: assert property (flash_cmd_o.prog == core_stall_o)
        else $error("program strobe and core stall disagree");
    a_word_addr_even: assert property (flash_cmd_o.prog |-> !flash_cmd_o.addr[0])
        else $error("word program address is odd");
    a_word_cmd_steady: assert property (flash_cmd_o.prog && $past(flash_cmd_o.prog) |->
        $stable(flash_cmd_o))
        else $error("flash command changed within a cycle");
    a_stall_ends: assert property ($rose(core_stall_o) |-> ##[1:STALL_MAX] !core_stall_o)
        else $error("program cycle did not end in time");
    a_start_cause: assert property ($rose(core_stall_o) |-> s_start_write)
        else $error("program cycle began without a start write");
endmodule : fwp_wp_assertions
bind fwp_word_program fwp_wp_assertions #(.PROG_TIME_NS(PROG_TIME_NS)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .core_stall_o(core_stall_o), .flash_cmd_o(flash_cmd_o)
);

// >>> verif/fwp_core_model.sv
// Purpose: processor core model issuing register and table writes
// Assumes: classic Wishbone, one request at a time
// Notes:   the core issues nothing while it is stalled
`timescale 1ns/100ps
module fwp_core_model (
    // clock and answers
    input  wire logic        clk_i,
    input  wire logic        wb_ack_i,
    input  wire logic        core_stall_i,
    // bus requests
    output logic             wb_cyc_o,
    output logic             wb_stb_o,
    output logic             wb_we_o,
    output logic [7:0]       wb_adr_o,
    output logic [3:0]       wb_sel_o,
    output logic [31:0]      wb_dat_o
);
    // idle bus from time zero
    initial begin
        {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
    end
    // one classic cycle, held until ack is sampled
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] dat);
        @(posedge clk_i);
        while (core_stall_i) @(posedge clk_i);
        {wb_cyc_o, wb_stb_o, wb_sel_o} <= {2'b11, 4'h1};
        wb_we_o  <= we;
        wb_adr_o <= adr;
        wb_dat_o <= {24'h00_0000, dat};
        do @(posedge clk_i); while (!wb_ack_i);
        {wb_cyc_o, wb_stb_o} <= 2'b00;
    endtask : xfer
    // load one word and launch it; a cut word is launched again at the same place
    task automatic start_word(input logic [21:0] ptr, input logic [7:0] lo, input logic [7:0] hi);
        xfer(1'b1, fwp_pkg::OFF_PTR_UPPER, {2'b00, ptr[21:16]});
        xfer(1'b1, fwp_pkg::OFF_PTR_HIGH, ptr[15:8]);
        xfer(1'b1, fwp_pkg::OFF_PTR_LOW, ptr[7:0]);
        xfer(1'b1, fwp_pkg::OFF_LATCH, lo);
        xfer(1'b1, fwp_pkg::OFF_TBL_WRITE, 8'h01);
        xfer(1'b1, fwp_pkg::OFF_LATCH, hi);
        xfer(1'b1, fwp_pkg::OFF_TBL_WRITE, 8'h00);
        xfer(1'b1, fwp_pkg::OFF_CTL, 8'h24);
        xfer(1'b1, fwp_pkg::OFF_INTCTL, 8'h00);
        xfer(1'b1, fwp_pkg::OFF_KEY, fwp_pkg::KEY_FIRST);
        xfer(1'b1, fwp_pkg::OFF_KEY, fwp_pkg::KEY_SECOND);
        xfer(1'b1, fwp_pkg::OFF_CTL, 8'h26);
    endtask : start_word
    // re-enable interrupts, then lock programming again
    task automatic finish_word();
        xfer(1'b1, fwp_pkg::OFF_INTCTL, 8'h80);
        xfer(1'b1, fwp_pkg::OFF_CTL, 8'h04);
        xfer(1'b1, fwp_pkg::OFF_CTL, 8'h00);
    endtask : finish_word
endmodule : fwp_core_model

// >>> verif/tb_flash_word_program_control.sv
// Purpose: self-checking bench of the word program controller
// Assumes: program time shortened to 10 clock cycles
// Notes:   expected reads and flash commands are queued by the driver
`timescale 1ns/100ps
module tb_flash_word_program_control;
    logic                       clk_i = 1'b0;
    logic                       rst_i = 1'b1;
    logic                       ext_rst = 1'b0;
    logic                       wdt_rst = 1'b0;
    logic                       cyc, stb, we, ack, stall, prog_q;
    logic [7:0]                 adr;
    logic [3:0]                 sel;
    logic [31:0]                wdat, rdat;
    fwp_pkg::fwp_flash_cmd_type cmd;
    logic [31:0]                q_rd[$];
    fwp_pkg::fwp_flash_cmd_type q_cmd[$];
    logic [21:0]                ptr;
    logic [7:0]                 lo, hi;
    int                         n_errors = 0;
    int                         compares = 0;
    int                         seed = 32'h7362;
    always #5 clk_i = ~clk_i;
    fwp_word_program #(.PROG_TIME_NS(100)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .external_master_reset_i(ext_rst), .watchdog_reset_i(wdt_rst),
        .core_stall_o(stall), .flash_cmd_o(cmd));
    fwp_core_model u_core (
        .clk_i(clk_i), .wb_ack_i(ack), .core_stall_i(stall), .wb_cyc_o(cyc), .wb_stb_o(stb),
        .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));
    // report and close the run
    task automatic give_verdict();
        if (n_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    // note the expected answer, then read
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        q_rd.push_back(exp);
        u_core.xfer(1'b0, a, 8'h00);
    endtask : rd
    // compare a read answer with the oldest note
    task automatic chk_rd(input logic [31:0] got);
        compares++;
        if (q_rd.size() == 0 || q_rd[0] !== got) begin
            n_errors++;
            $display("unexpected at %0t: read %h", $time, got);
        end
        if (q_rd.size() != 0) void'(q_rd.pop_front());
    endtask : chk_rd
    // compare a launched flash command with the oldest note
    task automatic chk_cmd(input fwp_pkg::fwp_flash_cmd_type got);
        compares++;
        if (q_cmd.size() == 0 || q_cmd[0] !== got) begin
            n_errors++;
            $display("unexpected at %0t: flash command %h", $time, got);
        end
        if (q_cmd.size() != 0) void'(q_cmd.pop_front());
    endtask : chk_cmd
    // watch answers and program launches
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0) chk_rd(rdat);
        if (cmd.prog === 1'b1 && prog_q !== 1'b1) chk_cmd(cmd);
        prog_q = cmd.prog;
    end
    // the whole run needs a few hundred cycles; this cuts a hang
    initial begin
        #200_000;
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(fwp_pkg::OFF_CTL, 32'h0000_0000);
        rd(fwp_pkg::OFF_PTR_UPPER, 32'h0000_0000);
        u_core.xfer(1'b1, fwp_pkg::OFF_PTR_UPPER, 8'hFF);
        rd(fwp_pkg::OFF_PTR_UPPER, 32'h0000_003F);
        u_core.xfer(1'b1, fwp_pkg::OFF_KEY, fwp_pkg::KEY_FIRST);
        rd(fwp_pkg::OFF_KEY, 32'h0000_0000);
        rd(8'h3C, 32'h0000_0000);
        // all ones into control: only bits 5, 4 and 2 keep a one, no start without the key
        u_core.xfer(1'b1, fwp_pkg::OFF_CTL, 8'hFF);
        rd(fwp_pkg::OFF_CTL, 32'h0000_0034);
        // start with only the first key value, a broken key and a reversed key
        for (int k = 0; k < 3; k++) begin
            u_core.xfer(1'b1, fwp_pkg::OFF_CTL, 8'h24);
            u_core.xfer(1'b1, fwp_pkg::OFF_KEY, k == 2 ? fwp_pkg::KEY_SECOND : fwp_pkg::KEY_FIRST);
            if (k == 1) u_core.xfer(1'b1, fwp_pkg::OFF_INTCTL, 8'h00);
            if (k != 0) u_core.xfer(1'b1, fwp_pkg::OFF_KEY, k == 2 ? 8'h55 : 8'hAA);
            u_core.xfer(1'b1, fwp_pkg::OFF_CTL, 8'h26);
            rd(fwp_pkg::OFF_CTL, 32'h0000_0024);
        end
        // random words; the second and fourth are cut short by a reset pin
        for (int w = 0; w < 4; w++) begin
            ptr = 22'($random(seed)) & 22'h3F_FFFE;
            lo  = 8'($random(seed));
            hi  = 8'($random(seed));
            q_cmd.push_back({1'b1, ptr, hi, lo});
            u_core.start_word(ptr, lo, hi);
            if (w == 1) ext_rst <= 1'b1;
            if (w == 3) wdt_rst <= 1'b1;
            repeat (4) @(posedge clk_i);
            {ext_rst, wdt_rst} <= 2'b00;
            rd(fwp_pkg::OFF_HOLD, {16'h0000, hi, lo});
            rd(fwp_pkg::OFF_PTR_LOW, {24'h00_0000, ptr[7:0] | 8'h01});
            rd(fwp_pkg::OFF_CTL, w[0] ? 32'h0000_002C : 32'h0000_0024);
            // a cut word: the flag survives a write of one, then the word is programmed again
            if (w[0]) begin
                u_core.xfer(1'b1, fwp_pkg::OFF_CTL, 8'h2C);
                rd(fwp_pkg::OFF_CTL, 32'h0000_002C);
                q_cmd.push_back({1'b1, ptr, hi, lo});
                u_core.start_word(ptr, lo, hi);
            end
            u_core.finish_word();
            rd(fwp_pkg::OFF_CTL, 32'h0000_0000);
        end
        repeat (2) @(posedge clk_i);
        compares++;
        if (q_rd.size() != 0 || q_cmd.size() != 0) begin
            n_errors++;
            $display("unexpected at %0t: notes left unanswered", $time);
        end
        give_verdict();
    end
endmodule : tb_flash_word_program_control
